// *** verilog/odc_ctrl.sv ***
// serial slave, load strobe and clear logic of the octal dac
//
// Behaviour
// (RL1) load strobe low copies pending inputs to dacs
// (RL2) load strobe may stay low permanently
// (RL3) address lsb comes from select pin
// (RL4) reference starts external until software enables internal
// (RL5) clear acts on its falling edge
// (RL6) clear held low blocks all load transfers
// (RL7) clear loads input and dac registers
// (RL8) clear code resets to zero scale
// (RL9) 32-bit shift register moves serial data
// (RL10) data line only pulled low or released
// (RL11) load comes 300 ns after last ack
// (RL12) load low pulse at least 10 ns
// (RL13) serial input spikes to 50 ns ignored
// (RL14) pending flag per channel set and cleared
// (RL15) clear wins over coinciding load
`default_nettype none
module odc_ctrl (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_ce,
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic i_load_strobe_n,
   input wire logic i_async_clear_n,
   input wire logic i_addr_select_pin,
   output logic o_sda_o,
   output logic o_sda_oe,
   output logic [127:0] o_dac,
   output logic [7:0] o_pending,
   output logic o_ref_internal
);
   localparam int SCL = 0;
   localparam int SDA = 1;
   localparam int LDS = 2;
   localparam int CLR = 3;
   localparam int ASEL = 4;

   function automatic logic [15:0] clr_value(input logic [1:0] code);
      unique case (code)
         odc_pkg::CLR_MID: clr_value = odc_pkg::CODE_MID;
         odc_pkg::CLR_FULL: clr_value = odc_pkg::CODE_FULL;
         default: clr_value = odc_pkg::CODE_ZERO;
      endcase
   endfunction

   // input synchronisers, spike filters and edge history
   logic [4:0] sync1, sync2;
   logic [1:0] filt, filt_d, next_filt;
   logic [2:0] fcnt [2];
   logic [2:0] next_fcnt [2];
   logic clr_d;
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         next_filt[i] = filt[i];
         next_fcnt[i] = 3'h0;
         if (sync2[i] != filt[i]) begin
            if (fcnt[i] == 3'(odc_pkg::SPIKE_CYC)) begin
               next_filt[i] = sync2[i]; // RL13
            end else begin
               next_fcnt[i] = fcnt[i] + 3'h1;
            end
         end
      end
   end
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         sync1 <= 5'h1F;
         sync2 <= 5'h1F;
         filt <= 2'h3;
         filt_d <= 2'h3;
         fcnt[0] <= 3'h0;
         fcnt[1] <= 3'h0;
         clr_d <= 1'b1;
      end else if (i_ce) begin
         sync1 <= {i_addr_select_pin, i_async_clear_n, i_load_strobe_n,
                   i_sda, i_scl};
         sync2 <= sync1;
         filt <= next_filt;
         filt_d <= filt;
         fcnt <= next_fcnt;
         clr_d <= sync2[CLR];
      end
   end

   logic scl_rise, scl_fall, start_c, stop_c;
   assign scl_rise = filt[SCL] && !filt_d[SCL];
   assign scl_fall = !filt[SCL] && filt_d[SCL];
   assign start_c = filt[SCL] && filt_d[SCL] && !filt[SDA] && filt_d[SDA];
   assign stop_c = filt[SCL] && filt_d[SCL] && filt[SDA] && !filt_d[SDA];

   // serial slave
   odc_pkg::odc_state_e state, next_state;
   logic [3:0] cnt, next_cnt;
   logic [31:0] sr, next_sr;
   logic [1:0] bytes, next_bytes;
   logic rw, next_rw, sda_oe, next_sda_oe, rbyte, next_rbyte;
   logic [7:0] tx, next_tx;
   logic [2:0] rd_ch, next_rd_ch;
   logic commit;
   logic [15:0] in_reg [8];
   logic [15:0] next_in [8];
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_sr = sr;
      next_bytes = bytes;
      next_rw = rw;
      next_sda_oe = sda_oe;
      next_rbyte = rbyte;
      next_tx = tx;
      commit = 1'b0;
      if (scl_rise && (state == odc_pkg::ODC_ADDR ||
                       state == odc_pkg::ODC_WR)) begin
         next_sr = {sr[30:0], filt[SDA]}; // RL9
         next_cnt = cnt + 4'h1;
      end
      if (scl_rise && state == odc_pkg::ODC_RD) begin
         next_cnt = cnt + 4'h1;
      end
      if (scl_fall) begin
         unique case (state)
            odc_pkg::ODC_IDLE: ;
            odc_pkg::ODC_ADDR: begin
               if (cnt == 4'h8) begin
                  if (sr[7:1] == {odc_pkg::ADDR_HI, sync2[ASEL]}) begin
                     next_state = odc_pkg::ODC_AACK; // RL3
                     next_sda_oe = 1'b1;
                     next_rw = sr[0];
                  end else begin
                     next_state = odc_pkg::ODC_IDLE; // RL3
                  end
               end
            end
            odc_pkg::ODC_AACK, odc_pkg::ODC_RACK: begin
               next_cnt = 4'h0;
               next_sda_oe = 1'b0;
               if (rw) begin
                  next_state = odc_pkg::ODC_RD;
                  next_tx = rbyte ? in_reg[rd_ch][7:0] : in_reg[rd_ch][15:8];
                  next_rbyte = !rbyte;
                  next_sda_oe = rbyte ? !in_reg[rd_ch][7] : !in_reg[rd_ch][15];
               end else begin
                  next_state = odc_pkg::ODC_WR;
               end
            end
            odc_pkg::ODC_WR: begin
               if (cnt == 4'h8) begin
                  next_state = odc_pkg::ODC_WACK;
                  next_sda_oe = 1'b1;
                  next_bytes = bytes + 2'h1;
               end
            end
            odc_pkg::ODC_WACK: begin
               next_sda_oe = 1'b0;
               next_cnt = 4'h0;
               next_state = odc_pkg::ODC_WR;
               if (bytes == 2'(odc_pkg::DATA_BYTES)) begin
                  commit = 1'b1;
                  next_bytes = 2'h0;
               end
            end
            odc_pkg::ODC_RD: begin
               // the line is only ever pulled low, never driven high
               if (cnt == 4'h8) begin
                  next_sda_oe = 1'b0; // RL10
                  next_state = odc_pkg::ODC_RACK;
               end else begin
                  next_tx = {tx[6:0], 1'b0};
                  next_sda_oe = !tx[6]; // RL10
               end
            end
            default: next_state = odc_pkg::ODC_IDLE;
         endcase
      end
      // a master nack ends the read
      if (scl_rise && state == odc_pkg::ODC_RACK && filt[SDA]) begin
         next_state = odc_pkg::ODC_IDLE;
      end
      if (start_c) begin
         next_state = odc_pkg::ODC_ADDR;
         next_cnt = 4'h0;
         next_bytes = 2'h0;
         next_rbyte = 1'b0;
         next_sda_oe = 1'b0;
      end else if (stop_c) begin
         next_state = odc_pkg::ODC_IDLE;
         next_sda_oe = 1'b0;
      end
   end
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state <= odc_pkg::ODC_IDLE;
         cnt <= 4'h0;
         sr <= 32'h0;
         bytes <= 2'h0;
         rw <= 1'b0;
         sda_oe <= 1'b0;
         rbyte <= 1'b0;
         tx <= 8'h0;
      end else if (i_ce) begin
         state <= next_state;
         cnt <= next_cnt;
         sr <= next_sr;
         bytes <= next_bytes;
         rw <= next_rw;
         sda_oe <= next_sda_oe;
         rbyte <= next_rbyte;
         tx <= next_tx;
      end
   end

   // register stages, clear and load
   logic [15:0] dac [8];
   logic [15:0] next_dac [8];
   logic [7:0] pending, next_pending;
   logic [1:0] clr_code, next_clr_code;
   logic ref_int, next_ref_int;
   logic clr_edge, load_ok;
   logic [3:0] cmd, chn;
   // edge found by sampling: a clear shorter than one clock may be missed
   assign clr_edge = !sync2[CLR] && clr_d; // RL5
   // level sensitive so a strobe tied low keeps updating
   assign load_ok = !sync2[LDS] && sync2[CLR] && clr_d; // RL1 RL2 RL6
   assign cmd = sr[23:20];
   assign chn = sr[19:16];
   always_comb begin
      next_in = in_reg;
      next_dac = dac;
      next_pending = pending;
      next_clr_code = clr_code;
      next_ref_int = ref_int;
      next_rd_ch = rd_ch;
      if (commit) begin
         next_rd_ch = chn[2:0];
         unique case (cmd)
            odc_pkg::CMD_WR_IN, odc_pkg::CMD_WR_UPD: begin
               for (int c = 0; c < odc_pkg::N_CH; c++) begin
                  if (chn == odc_pkg::CH_ALL || chn[2:0] == 3'(c)) begin
                     next_in[c] = sr[15:0];
                     next_pending[c] = 1'b1; // RL14
                     if (cmd == odc_pkg::CMD_WR_UPD && sync2[CLR]) begin
                        next_dac[c] = sr[15:0];
                        next_pending[c] = 1'b0; // RL14
                     end
                  end
               end
            end
            odc_pkg::CMD_CLR_CODE: next_clr_code = sr[1:0];
            odc_pkg::CMD_REF: next_ref_int = sr[0]; // RL4
            default: ;
         endcase
      end
      if (load_ok) begin
         for (int c = 0; c < odc_pkg::N_CH; c++) begin
            if (next_pending[c]) begin
               next_dac[c] = next_in[c]; // RL1
            end
         end
         next_pending = 8'h0; // RL14
      end
      if (clr_edge) begin
         for (int c = 0; c < odc_pkg::N_CH; c++) begin
            next_in[c] = clr_value(clr_code); // RL7
            next_dac[c] = clr_value(clr_code); // RL7 RL15
         end
         next_pending = 8'h0; // RL14
      end
   end
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         for (int c = 0; c < odc_pkg::N_CH; c++) begin
            in_reg[c] <= odc_pkg::DAC_RST;
            dac[c] <= odc_pkg::DAC_RST;
         end
         pending <= 8'h0;
         clr_code <= odc_pkg::CLR_CODE_RST; // RL8
         ref_int <= odc_pkg::REF_INT_RST; // RL4
         rd_ch <= 3'h0;
      end else if (i_ce) begin
         in_reg <= next_in;
         dac <= next_dac;
         pending <= next_pending;
         clr_code <= next_clr_code;
         ref_int <= next_ref_int;
         rd_ch <= next_rd_ch;
      end
   end

   assign o_sda_o = 1'b0; // RL10
   assign o_sda_oe = sda_oe;
   assign o_dac = {dac[7], dac[6], dac[5], dac[4],
                   dac[3], dac[2], dac[1], dac[0]};
   assign o_pending = pending;
   assign o_ref_internal = ref_int;

   property p_clr_blocks;
      @(posedge i_clk) disable iff (!i_arst_n)
      (i_ce && !sync2[CLR] && !clr_d && !commit) |=> $stable(o_dac);
   endproperty
   a_clr_blocks: assert property (p_clr_blocks) // RL6
      else $error("dac changed while clear held low");
   property p_clr_load;
      @(posedge i_clk) disable iff (!i_arst_n)
      (i_ce && clr_edge) |=> (dac[0] == clr_value(clr_code) &&
                             in_reg[7] == clr_value(clr_code));
   endproperty
   a_clr_load: assert property (p_clr_load) // RL7
      else $error("clear did not load the clear code");
   property p_clr_prio;
      @(posedge i_clk) disable iff (!i_arst_n)
      (i_ce && clr_edge && !sync2[LDS]) |=> dac[3] == clr_value(clr_code);
   endproperty
   a_clr_prio: assert property (p_clr_prio) // RL15
      else $error("load beat a coinciding clear");
   property p_load_copy;
      @(posedge i_clk) disable iff (!i_arst_n)
      (i_ce && load_ok && !commit && pending[2]) |=>
         dac[2] == $past(in_reg[2]);
   endproperty
   a_load_copy: assert property (p_load_copy) // RL1
      else $error("load did not copy the input register");
   property p_pend_clear;
      @(posedge i_clk) disable iff (!i_arst_n)
      (i_ce && load_ok) |=> o_pending == 8'h0;
   endproperty
   a_pend_clear: assert property (p_pend_clear) // RL14
      else $error("pending flags survived a load");
   property p_addr;
      @(posedge i_clk) disable iff (!i_arst_n)
      (i_ce && scl_fall && !start_c && !stop_c && state == odc_pkg::ODC_ADDR
       && cnt == 4'h8 && sr[7:1] != {odc_pkg::ADDR_HI, sync2[ASEL]})
      |=> state == odc_pkg::ODC_IDLE && !o_sda_oe;
   endproperty
   a_addr: assert property (p_addr) // RL3
      else $error("answered a foreign address");
   property p_spike;
      @(posedge i_clk) disable iff (!i_arst_n)
      (i_ce && $rose(filt[SCL])) |->
         ($past(sync2[SCL], 1) && $past(sync2[SCL], 6));
   endproperty
   a_spike: assert property (p_spike) // RL13
      else $error("clock filter passed a short pulse");
   property p_ref;
      @(posedge i_clk) disable iff (!i_arst_n)
      $rose(o_ref_internal) |-> $past(commit && cmd == odc_pkg::CMD_REF);
   endproperty
   a_ref: assert property (p_ref) // RL4
      else $error("reference switched without a command");
   property p_shift;
      @(posedge i_clk) disable iff (!i_arst_n)
      (i_ce && scl_rise && state == odc_pkg::ODC_WR) |=>
         sr[0] == $past(filt[SDA]);
   endproperty
   a_shift: assert property (p_shift) // RL9
      else $error("shift register missed a bit");
endmodule
`default_nettype wire

// *** verilog/odc_pkg.sv ***
// constants for the octal dac load and clear control block
`default_nettype none
package odc_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int SPIKE_NS = 50;
   // a spike up to this many cycles long never reaches the bus logic
   localparam int SPIKE_CYC = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int N_CH = 8;
   localparam int DAC_W = 16;
   localparam int SR_W = 32;
   localparam int ADDR_W = 7;
   localparam int DATA_BYTES = 3;
   // upper six address bits; value is arbitrary
   localparam logic [5:0] ADDR_HI = 6'h2A;
   // command nibble of the first data byte
   localparam logic [3:0] CMD_WR_IN = 4'h0;
   localparam logic [3:0] CMD_WR_UPD = 4'h3;
   localparam logic [3:0] CMD_CLR_CODE = 4'h5;
   localparam logic [3:0] CMD_REF = 4'h8;
   localparam logic [3:0] CH_ALL = 4'hF;
   localparam logic [1:0] CLR_ZERO = 2'h0;
   localparam logic [1:0] CLR_MID = 2'h1;
   localparam logic [1:0] CLR_FULL = 2'h2;
   localparam logic [15:0] CODE_ZERO = 16'h0000;
   localparam logic [15:0] CODE_MID = 16'h8000;
   localparam logic [15:0] CODE_FULL = 16'hFFFF;
   localparam logic [1:0] CLR_CODE_RST = CLR_ZERO;
   localparam logic REF_INT_RST = 1'b0;
   localparam logic [15:0] DAC_RST = CODE_ZERO;
   typedef enum logic [2:0] {
      ODC_IDLE = 3'h0,
      ODC_ADDR = 3'h1,
      ODC_AACK = 3'h3,
      ODC_WR = 3'h2,
      ODC_WACK = 3'h6,
      ODC_RD = 3'h7,
      ODC_RACK = 3'h5
   } odc_state_e;
endpackage
`default_nettype wire

// *** test/odc_master.sv ***
// partner model: serial bus master that also drives load and clear pins
`default_nettype none
module odc_master (
   input wire logic i_clk,
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda_oe,
   output logic o_load_strobe_n,
   output logic o_async_clear_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic spk;
   // idle bus: both lines released, strobes inactive
   initial begin
      o_scl = 1'b1;
      o_sda_oe = 1'b0;
      o_load_strobe_n = 1'b1;
      o_async_clear_n = 1'b1;
      spk = 1'b0;
   end
   task automatic half(input int n = 8);
      repeat (n) @(negedge i_clk);
   endtask
   // data changes mid-low so it never races the clock edge after filtering
   task automatic xbit(input logic b, output logic r);
      o_sda_oe = !b;
      half();
      o_scl = 1'b1;
      if (spk) begin
         half(3);
         o_sda_oe = b;
         half(3);
         o_sda_oe = !b;
         half(2);
      end else begin
         half();
      end
      r = i_sda;
      o_scl = 1'b0;
      half();
   endtask
   task automatic xbyte(input logic [7:0] d, input logic mack,
                        output logic [7:0] q, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         xbit(d[i], r);
         q[i] = r;
      end
      xbit(!mack, r);
      ack = !r;
   endtask
   task automatic start();
      o_sda_oe = 1'b1;
      half();
      o_scl = 1'b0;
      half();
   endtask
   task automatic stop();
      o_sda_oe = 1'b1;
      half();
      o_scl = 1'b1;
      half();
      o_sda_oe = 1'b0;
      half(16);
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] c,
                     input logic [15:0] d, output logic ok);
      logic [7:0] q;
      logic k0, k1, k2, k3;
      start();
      xbyte({a, 1'b0}, 1'b0, q, k0);
      xbyte(c, 1'b0, q, k1);
      xbyte(d[15:8], 1'b0, q, k2);
      xbyte(d[7:0], 1'b0, q, k3);
      stop();
      ok = k0 & k1 & k2 & k3;
   endtask
   // last byte gets no ack from us, which ends the read
   task automatic rd(input logic [6:0] a, output logic [15:0] v,
                     output logic ok);
      logic k;
      start();
      xbyte({a, 1'b1}, 1'b0, v[15:8], ok);
      xbyte(8'hFF, 1'b1, v[15:8], k);
      xbyte(8'hFF, 1'b0, v[7:0], k);
      stop();
   endtask
   task automatic ld_set(input logic v);
      o_load_strobe_n = v;
      half(4);
   endtask
   task automatic clr_set(input logic v);
      o_async_clear_n = v;
      half(4);
   endtask
   task automatic ld_pulse();
      half(32);
      ld_set(1'b0);
      ld_set(1'b1);
   endtask
   task automatic both_low();
      o_async_clear_n = 1'b0;
      o_load_strobe_n = 1'b0;
      half(4);
      o_async_clear_n = 1'b1;
      o_load_strobe_n = 1'b1;
      half(4);
   endtask
endmodule
`default_nettype wire

// *** test/odc_ctrl_tb.sv ***
// self-checking testbench for the octal dac load and clear control
`default_nettype none
module odc_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [6:0] A1 = {odc_pkg::ADDR_HI, 1'b1};
   localparam logic [6:0] A0 = {odc_pkg::ADDR_HI, 1'b0};
   logic clk;
   logic arst_n;
   logic pin;
   logic ce;
   int err_count = 0;
   int checked = 0;
   wire scl, mst_oe, ld_n, clr_n, sda_o, sda_oe, ref_int;
   wire [127:0] dac;
   wire [7:0] pend;
   // pulled-up open-drain wire
   wire sda = !(mst_oe || (sda_oe && !sda_o));
   odc_ctrl u_odc_ctrl (.i_clk(clk), .i_arst_n(arst_n), .i_ce(ce),
      .i_scl(scl), .i_sda(sda), .i_load_strobe_n(ld_n),
      .i_async_clear_n(clr_n), .i_addr_select_pin(pin), .o_sda_o(sda_o),
      .o_sda_oe(sda_oe), .o_dac(dac), .o_pending(pend),
      .o_ref_internal(ref_int));
   odc_master u_odc_master (.i_clk(clk), .i_sda(sda), .o_scl(scl),
      .o_sda_oe(mst_oe), .o_load_strobe_n(ld_n), .o_async_clear_n(clr_n));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (sda_oe === 1'b1 && sda_o !== 1'b0) begin
         err_count++;
         $display("MISMATCH sda_o expected 0 seen %b", sda_o);
      end
   end
   task automatic chk(input string n, input logic [15:0] e,
                      input logic [15:0] g);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   function automatic logic [15:0] dv(input int c);
      return dac[16*c +: 16];
   endfunction
   task automatic chk_all(input string n, input logic [15:0] e);
      for (int c = 0; c < 8; c++) chk(n, e, dv(c));
   endtask
   task automatic t_reset();
      logic ok;
      chk_all("dac at reset", odc_pkg::DAC_RST);
      chk("pending", 16'h0000, {8'h00, pend});
      chk("ref", 16'h0000, {15'h0000, ref_int});
      // a nonzero channel first, so the default clear has work to do
      u_odc_master.wr(A1, {odc_pkg::CMD_WR_UPD, 4'h1}, 16'h7777, ok);
      chk("dac1 write update", 16'h7777, dv(1));
      chk("pending after update", 16'h0000, {8'h00, pend});
      u_odc_master.clr_set(1'b0);
      u_odc_master.clr_set(1'b1);
      chk_all("dac default clear", odc_pkg::CODE_ZERO);
      $display("test reset done");
   endtask
   task automatic t_load();
      logic ok;
      u_odc_master.wr(A0, 8'h02, 16'h1234, ok);
      chk("ack other addr", 16'h0000, {15'h0000, ok});
      u_odc_master.wr(A1, {odc_pkg::CMD_WR_IN, 4'h2}, 16'h1234, ok);
      chk("ack", 16'h0001, {15'h0000, ok});
      u_odc_master.spk = 1'b1;
      u_odc_master.wr(A1, {odc_pkg::CMD_WR_IN, 4'h3}, 16'hA5C3, ok);
      u_odc_master.spk = 1'b0;
      chk("pending", 16'h000C, {8'h00, pend});
      chk("dac2 before load", 16'h0000, dv(2));
      u_odc_master.ld_pulse();
      chk("dac2", 16'h1234, dv(2));
      chk("dac3", 16'hA5C3, dv(3));
      chk("pending after load", 16'h0000, {8'h00, pend});
      $display("test load done");
   endtask
   task automatic t_read();
      logic [15:0] v;
      logic ok;
      u_odc_master.rd(A1, v, ok);
      chk("read ack", 16'h0001, {15'h0000, ok});
      chk("read data", 16'hA5C3, v);
      $display("test read done");
   endtask
   task automatic t_clear();
      logic [15:0] v;
      logic ok;
      u_odc_master.wr(A1, {odc_pkg::CMD_CLR_CODE, 4'h0}, 16'h0001, ok);
      u_odc_master.clr_set(1'b0);
      chk_all("dac mid", odc_pkg::CODE_MID);
      u_odc_master.wr(A1, {odc_pkg::CMD_WR_IN, 4'h4}, 16'h0F0F, ok);
      u_odc_master.ld_pulse();
      chk("dac4 clear low", odc_pkg::CODE_MID, dv(4));
      u_odc_master.clr_set(1'b1);
      u_odc_master.ld_pulse();
      chk("dac4", 16'h0F0F, dv(4));
      u_odc_master.wr(A1, {odc_pkg::CMD_CLR_CODE, 4'h0}, 16'h0002, ok);
      u_odc_master.wr(A1, {odc_pkg::CMD_WR_IN, 4'h6}, 16'h1111, ok);
      u_odc_master.both_low();
      chk_all("dac full", odc_pkg::CODE_FULL);
      chk("pending", 16'h0000, {8'h00, pend});
      u_odc_master.rd(A1, v, ok);
      chk("input after clear", odc_pkg::CODE_FULL, v);
      $display("test clear done");
   endtask
   task automatic t_tied();
      logic ok;
      u_odc_master.ld_set(1'b0);
      u_odc_master.wr(A1, {odc_pkg::CMD_WR_IN, 4'h5}, 16'hBEEF, ok);
      chk("dac5 tied low", 16'hBEEF, dv(5));
      chk("pending", 16'h0000, {8'h00, pend});
      u_odc_master.ld_set(1'b1);
      $display("test tied load done");
   endtask
   task automatic t_ref();
      logic ok;
      pin = 1'b0;
      u_odc_master.half(4);
      u_odc_master.wr(A0, {odc_pkg::CMD_REF, 4'h0}, 16'h0001, ok);
      chk("ack pin low", 16'h0001, {15'h0000, ok});
      chk("ref internal", 16'h0001, {15'h0000, ref_int});
      pin = 1'b1;
      $display("test ref done");
   endtask
   // with the enable low even the clear pin must go unseen
   task automatic t_ce();
      ce = 1'b0;
      u_odc_master.clr_set(1'b0);
      u_odc_master.clr_set(1'b1);
      ce = 1'b1;
      u_odc_master.half(4);
      chk("dac5 frozen", 16'hBEEF, dv(5));
      u_odc_master.clr_set(1'b0);
      u_odc_master.clr_set(1'b1);
      chk("dac5 cleared", odc_pkg::CODE_FULL, dv(5));
      $display("test clock enable done");
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (100000) @(posedge clk);
      err_count++;
      wrap_up();
   end
   initial begin
      arst_n = 1'b0;
      pin = 1'b1;
      ce = 1'b1;
      repeat (2) @(posedge clk);
      @(negedge clk);
      arst_n = 1'b1;
      repeat (2) @(negedge clk);
      t_reset();
      t_load();
      t_read();
      t_clear();
      t_tied();
      t_ref();
      t_ce();
      wrap_up();
   end
endmodule
`default_nettype wire
